// ==== hdl/cie_core.sv ====
`timescale 1ns/1ps
module cie_core (
  // Clock and reset
  input  logic        clk_sys,
  input  logic        rst_b,
  // Instruction port
  input  logic        ins_valid,
  input  logic [4:0]  ins_op,
  input  logic [4:0]  ins_d,
  input  logic [4:0]  ins_r,
  input  logic [15:0] ins_k,
  input  logic [5:0]  ins_q,
  input  logic [2:0]  ins_b,
  input  logic [1:0]  ins_ptr,
  input  logic [1:0]  ins_mode,
  output logic        ins_ready,
  // Core state
  output logic [15:0] pc,
  output logic [7:0]  status_flags,
  // Data memory
  output logic [15:0] dm_addr,
  output logic [7:0]  dm_wdata,
  output logic        dm_we,
  output logic        dm_re,
  input  logic [7:0]  dm_rdata,
  // Program memory
  output logic [14:0] pm_addr,
  output logic        pm_re,
  input  logic [15:0] pm_rdata,
  // I/O space
  output logic [4:0]  io_addr,
  output logic [7:0]  io_wdata,
  output logic        io_we,
  output logic        io_re,
  input  logic [7:0]  io_rdata,
  // Register bus
  input  logic [5:0]  rb_addr,
  input  logic [7:0]  rb_wdata,
  input  logic        rb_wr,
  input  logic        rb_rd,
  output logic [7:0]  rb_rdata
);

  logic [1:0]          rst_sync_ff;
  logic                rst_n;

  cie_pkg::cie_state_t state_ff;
  cie_pkg::cie_state_t nxt_state;
  logic [7:0]          gpr_ff [32];
  logic [7:0]          nxt_gpr [32];
  logic [15:0]         pc_ff;
  logic [15:0]         nxt_pc;
  logic [15:0]         sp_ff;
  logic [15:0]         nxt_sp;
  logic [7:0]          stat_ff;
  logic [7:0]          nxt_stat;
  logic                ready_ff;
  logic                nxt_ready;
  logic [4:0]          dst_ff;
  logic [4:0]          nxt_dst;
  logic [2:0]          bit_ff;
  logic [2:0]          nxt_bit;
  logic                set_ff;
  logic                nxt_set;
  logic                hisel_ff;
  logic                nxt_hisel;
  logic [15:0]         dm_addr_ff;
  logic [15:0]         nxt_dm_addr;
  logic [7:0]          dm_wdata_ff;
  logic [7:0]          nxt_dm_wdata;
  logic                dm_we_ff;
  logic                nxt_dm_we;
  logic                dm_re_ff;
  logic                nxt_dm_re;
  logic [14:0]         pm_addr_ff;
  logic [14:0]         nxt_pm_addr;
  logic                pm_re_ff;
  logic                nxt_pm_re;
  logic [4:0]          io_addr_ff;
  logic [4:0]          nxt_io_addr;
  logic [7:0]          io_wdata_ff;
  logic [7:0]          nxt_io_wdata;
  logic                io_we_ff;
  logic                nxt_io_we;
  logic                io_re_ff;
  logic                nxt_io_re;
  logic [7:0]          rb_rdata_ff;
  logic [7:0]          nxt_rb_rdata;

  logic [4:0]          pb;
  logic [15:0]         ptr;
  logic [15:0]         nptr;
  logic [15:0]         addr;
  logic [7:0]          src;
  logic [7:0]          res;
  cie_pkg::cie_op_t    op;

  function automatic logic [4:0] ptr_base(input logic [1:0] sel);
    if (sel == cie_pkg::PTR_Z) begin
      return cie_pkg::Z_LO;
    end
    if (sel == cie_pkg::PTR_Y) begin
      return cie_pkg::Y_LO;
    end
    return cie_pkg::X_LO;
  endfunction

  function automatic logic [15:0] br_target(input logic [15:0] p,
                                            input logic [15:0] k);
    return p + {{9{k[6]}}, k[6:0]} + 16'h0001;
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  assign op = cie_pkg::cie_op_t'(ins_op);

  always_comb begin
    nxt_state    = state_ff;
    nxt_gpr      = gpr_ff;
    nxt_pc       = pc_ff;
    nxt_sp       = sp_ff;
    nxt_stat     = stat_ff;
    nxt_dst      = dst_ff;
    nxt_bit      = bit_ff;
    nxt_set      = set_ff;
    nxt_hisel    = hisel_ff;
    nxt_dm_addr  = dm_addr_ff;
    nxt_dm_wdata = dm_wdata_ff;
    nxt_dm_we    = 1'b0;
    nxt_dm_re    = 1'b0;
    nxt_pm_addr  = pm_addr_ff;
    nxt_pm_re    = 1'b0;
    nxt_io_addr  = io_addr_ff;
    nxt_io_wdata = io_wdata_ff;
    nxt_io_we    = 1'b0;
    nxt_io_re    = 1'b0;
    nxt_rb_rdata = rb_rdata_ff;
    pb           = ptr_base(ins_ptr);
    ptr          = {gpr_ff[pb + 5'h01], gpr_ff[pb]};
    nptr         = ptr;
    addr         = ptr;
    src          = gpr_ff[ins_d];
    res          = src;

    // Bus writes first so that the executing instruction wins
    if (rb_wr) begin
      if (!rb_addr[5]) begin
        nxt_gpr[rb_addr[4:0]] = rb_wdata;
      end else if (rb_addr == cie_pkg::RA_STATUS) begin
        nxt_stat = rb_wdata;
      end
    end
    if (rb_rd) begin
      if (!rb_addr[5]) begin
        nxt_rb_rdata = gpr_ff[rb_addr[4:0]];
      end else if (rb_addr == cie_pkg::RA_STATUS) begin
        nxt_rb_rdata = stat_ff;
      end else if (rb_addr == cie_pkg::RA_SP_LO) begin
        nxt_rb_rdata = sp_ff[7:0];
      end else if (rb_addr == cie_pkg::RA_SP_HI) begin
        nxt_rb_rdata = sp_ff[15:8];
      end else begin
        nxt_rb_rdata = 8'h00;
      end
    end

    unique case (state_ff)
      cie_pkg::SM_IDLE: begin
        // Nothing is taken while ready is low, even straight after reset
        if (ins_valid && ready_ff) begin
          nxt_pc = pc_ff + 16'h0001;
          unique case (ins_mode)
            cie_pkg::AM_POSTINC: begin
              nptr = ptr + 16'h0001;
            end
            cie_pkg::AM_PREDEC: begin
              nptr = ptr - 16'h0001;
              addr = nptr;
            end
            cie_pkg::AM_DISP: begin
              addr = ptr + {10'h000, ins_q};
            end
            cie_pkg::AM_PLAIN: begin
              addr = ptr;
            end
          endcase
          unique case (op)
            cie_pkg::OP_BRTCLR: begin
              if (!stat_ff[cie_pkg::FLG_T]) begin
                nxt_pc    = br_target(pc_ff, ins_k);
                nxt_state = cie_pkg::SM_HOLD;
              end
            end
            cie_pkg::OP_BRVSET, cie_pkg::OP_BRVCLR: begin
              if (stat_ff[cie_pkg::FLG_V] == (op == cie_pkg::OP_BRVSET)) begin
                nxt_pc    = br_target(pc_ff, ins_k);
                nxt_state = cie_pkg::SM_HOLD;
              end
            end
            cie_pkg::OP_BRIEN, cie_pkg::OP_BRIDIS: begin
              if (stat_ff[cie_pkg::FLG_I] == (op == cie_pkg::OP_BRIEN)) begin
                nxt_pc    = br_target(pc_ff, ins_k);
                nxt_state = cie_pkg::SM_HOLD;
              end
            end
            cie_pkg::OP_LDIND, cie_pkg::OP_STIND: begin
              if (ins_mode != cie_pkg::AM_DISP) begin
                nxt_gpr[pb]          = nptr[7:0];
                nxt_gpr[pb + 5'h01]  = nptr[15:8];
              end
              nxt_dm_addr  = addr;
              nxt_dm_wdata = gpr_ff[ins_r];
              nxt_dm_re    = (op == cie_pkg::OP_LDIND);
              nxt_dm_we    = (op == cie_pkg::OP_STIND);
              nxt_dst      = ins_d;
              nxt_state    = (op == cie_pkg::OP_LDIND) ?
                             cie_pkg::SM_LOAD : cie_pkg::SM_HOLD;
            end
            cie_pkg::OP_LDDIR, cie_pkg::OP_STDIR: begin
              nxt_pc       = pc_ff + 16'h0002;
              nxt_dm_addr  = ins_k;
              nxt_dm_wdata = gpr_ff[ins_r];
              nxt_dm_re    = (op == cie_pkg::OP_LDDIR);
              nxt_dm_we    = (op == cie_pkg::OP_STDIR);
              nxt_dst      = ins_d;
              nxt_state    = (op == cie_pkg::OP_LDDIR) ?
                             cie_pkg::SM_LOAD : cie_pkg::SM_HOLD;
            end
            cie_pkg::OP_PMRD, cie_pkg::OP_PMRD_R0: begin
              ptr         = {gpr_ff[cie_pkg::Z_LO + 5'h01],
                             gpr_ff[cie_pkg::Z_LO]};
              nxt_pm_addr = ptr[15:1];
              nxt_hisel   = ptr[0];
              nxt_pm_re   = 1'b1;
              nxt_dst     = (op == cie_pkg::OP_PMRD_R0) ? 5'h00 : ins_d;
              if (op == cie_pkg::OP_PMRD &&
                  ins_mode == cie_pkg::AM_POSTINC) begin
                nptr = ptr + 16'h0001;
                nxt_gpr[cie_pkg::Z_LO]         = nptr[7:0];
                nxt_gpr[cie_pkg::Z_LO + 5'h01] = nptr[15:8];
              end
              nxt_state   = cie_pkg::SM_PM1;
            end
            cie_pkg::OP_PUSH: begin
              nxt_dm_addr  = sp_ff;
              nxt_dm_wdata = gpr_ff[ins_r];
              nxt_dm_we    = 1'b1;
              nxt_sp       = sp_ff - 16'h0001;
              nxt_state    = cie_pkg::SM_HOLD;
            end
            cie_pkg::OP_POP: begin
              nxt_sp      = sp_ff + 16'h0001;
              nxt_dm_addr = sp_ff + 16'h0001;
              nxt_dm_re   = 1'b1;
              nxt_dst     = ins_d;
              nxt_state   = cie_pkg::SM_LOAD;
            end
            cie_pkg::OP_IOSET, cie_pkg::OP_IOCLR: begin
              nxt_io_addr = ins_k[4:0];
              nxt_io_re   = 1'b1;
              nxt_bit     = ins_b;
              nxt_set     = (op == cie_pkg::OP_IOSET);
              nxt_state   = cie_pkg::SM_IORMW;
            end
            cie_pkg::OP_ROLC: begin
              res = {src[6:0], stat_ff[cie_pkg::FLG_C]};
              nxt_gpr[ins_d] = res;
              nxt_stat[cie_pkg::FLG_C] = src[7];
              nxt_stat[cie_pkg::FLG_N] = res[7];
              nxt_stat[cie_pkg::FLG_Z] = (res == 8'h00);
              nxt_stat[cie_pkg::FLG_V] = res[7] ^ src[7];
            end
            cie_pkg::OP_RORC: begin
              res = {stat_ff[cie_pkg::FLG_C], src[7:1]};
              nxt_gpr[ins_d] = res;
              nxt_stat[cie_pkg::FLG_C] = src[0];
              nxt_stat[cie_pkg::FLG_N] = res[7];
              nxt_stat[cie_pkg::FLG_Z] = (res == 8'h00);
              nxt_stat[cie_pkg::FLG_V] = res[7] ^ src[0];
            end
            cie_pkg::OP_BIT2T: begin
              nxt_stat[cie_pkg::FLG_T] = gpr_ff[ins_r][ins_b];
            end
            cie_pkg::OP_T2BIT: begin
              nxt_gpr[ins_d][ins_b] = stat_ff[cie_pkg::FLG_T];
            end
            cie_pkg::OP_SETS, cie_pkg::OP_CLRS: begin
              nxt_stat[cie_pkg::FLG_S] = op == cie_pkg::OP_SETS;
            end
            cie_pkg::OP_SETV, cie_pkg::OP_CLRV: begin
              nxt_stat[cie_pkg::FLG_V] = op == cie_pkg::OP_SETV;
            end
            cie_pkg::OP_SETH, cie_pkg::OP_CLRH: begin
              nxt_stat[cie_pkg::FLG_H] = op == cie_pkg::OP_SETH;
            end
            default: begin
              nxt_pc = pc_ff + 16'h0001;
            end
          endcase
        end
      end
      cie_pkg::SM_HOLD: begin
        nxt_state = cie_pkg::SM_IDLE;
      end
      cie_pkg::SM_LOAD: begin
        nxt_gpr[dst_ff] = dm_rdata;
        nxt_state       = cie_pkg::SM_IDLE;
      end
      cie_pkg::SM_IORMW: begin
        nxt_io_wdata          = io_rdata;
        nxt_io_wdata[bit_ff]  = set_ff;
        nxt_io_we             = 1'b1;
        nxt_state             = cie_pkg::SM_IDLE;
      end
      cie_pkg::SM_PM1: begin
        nxt_state = cie_pkg::SM_PM2;
      end
      cie_pkg::SM_PM2: begin
        nxt_gpr[dst_ff] = hisel_ff ? pm_rdata[15:8] : pm_rdata[7:0];
        nxt_state       = cie_pkg::SM_IDLE;
      end
      default: begin
        nxt_state = cie_pkg::SM_IDLE;
      end
    endcase
    nxt_ready = (nxt_state == cie_pkg::SM_IDLE);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= cie_pkg::SM_IDLE;
      for (int i = 0; i < 32; i++) begin
        gpr_ff[i] <= 8'h00;
      end
      pc_ff       <= cie_pkg::PC_RST;
      sp_ff       <= cie_pkg::SP_RST;
      stat_ff     <= cie_pkg::STAT_RST;
      ready_ff    <= 1'b0;
      dst_ff      <= 5'h00;
      bit_ff      <= 3'h0;
      set_ff      <= 1'b0;
      hisel_ff    <= 1'b0;
      dm_addr_ff  <= 16'h0000;
      dm_wdata_ff <= 8'h00;
      dm_we_ff    <= 1'b0;
      dm_re_ff    <= 1'b0;
      pm_addr_ff  <= 15'h0000;
      pm_re_ff    <= 1'b0;
      io_addr_ff  <= 5'h00;
      io_wdata_ff <= 8'h00;
      io_we_ff    <= 1'b0;
      io_re_ff    <= 1'b0;
      rb_rdata_ff <= 8'h00;
    end else begin
      state_ff    <= nxt_state;
      gpr_ff      <= nxt_gpr;
      pc_ff       <= nxt_pc;
      sp_ff       <= nxt_sp;
      stat_ff     <= nxt_stat;
      ready_ff    <= nxt_ready;
      dst_ff      <= nxt_dst;
      bit_ff      <= nxt_bit;
      set_ff      <= nxt_set;
      hisel_ff    <= nxt_hisel;
      dm_addr_ff  <= nxt_dm_addr;
      dm_wdata_ff <= nxt_dm_wdata;
      dm_we_ff    <= nxt_dm_we;
      dm_re_ff    <= nxt_dm_re;
      pm_addr_ff  <= nxt_pm_addr;
      pm_re_ff    <= nxt_pm_re;
      io_addr_ff  <= nxt_io_addr;
      io_wdata_ff <= nxt_io_wdata;
      io_we_ff    <= nxt_io_we;
      io_re_ff    <= nxt_io_re;
      rb_rdata_ff <= nxt_rb_rdata;
    end
  end

  assign ins_ready    = ready_ff;
  assign pc           = pc_ff;
  assign status_flags = stat_ff;
  assign dm_addr      = dm_addr_ff;
  assign dm_wdata     = dm_wdata_ff;
  assign dm_we        = dm_we_ff;
  assign dm_re        = dm_re_ff;
  assign pm_addr      = pm_addr_ff;
  assign pm_re        = pm_re_ff;
  assign io_addr      = io_addr_ff;
  assign io_wdata     = io_wdata_ff;
  assign io_we        = io_we_ff;
  assign io_re        = io_re_ff;
  assign rb_rdata     = rb_rdata_ff;

endmodule

// ==== hdl/cie_pkg.sv ====
package cie_pkg;

  // Instruction codes presented on the instruction port
  typedef enum logic [4:0] {
    OP_NOP      = 5'h00,
    OP_BRTCLR   = 5'h01,
    OP_BRVSET   = 5'h02,
    OP_BRVCLR   = 5'h03,
    OP_BRIEN    = 5'h04,
    OP_BRIDIS   = 5'h05,
    OP_LDIND    = 5'h06,
    OP_STIND    = 5'h07,
    OP_LDDIR    = 5'h08,
    OP_STDIR    = 5'h09,
    OP_PMRD     = 5'h0a,
    OP_PMRD_R0  = 5'h0b,
    OP_PUSH     = 5'h0c,
    OP_POP      = 5'h0d,
    OP_IOSET    = 5'h0e,
    OP_IOCLR    = 5'h0f,
    OP_ROLC     = 5'h10,
    OP_RORC     = 5'h11,
    OP_BIT2T    = 5'h12,
    OP_T2BIT    = 5'h13,
    OP_SETS     = 5'h14,
    OP_CLRS     = 5'h15,
    OP_SETV     = 5'h16,
    OP_CLRV     = 5'h17,
    OP_SETH     = 5'h18,
    OP_CLRH     = 5'h19
  } cie_op_t;

  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } cie_ptr_t;

  typedef enum logic [1:0] {
    AM_PLAIN   = 2'h0,
    AM_POSTINC = 2'h1,
    AM_PREDEC  = 2'h2,
    AM_DISP    = 2'h3
  } cie_amode_t;

  typedef enum logic [2:0] {
    SM_IDLE  = 3'h0,
    SM_HOLD  = 3'h1,
    SM_LOAD  = 3'h2,
    SM_IORMW = 3'h3,
    SM_PM1   = 3'h4,
    SM_PM2   = 3'h5
  } cie_state_t;

  // Status flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  // Low register of each pointer pair
  localparam logic [4:0] X_LO = 5'h1a;
  localparam logic [4:0] Y_LO = 5'h1c;
  localparam logic [4:0] Z_LO = 5'h1e;

  // Register bus map above the general registers
  localparam logic [5:0] RA_STATUS = 6'h20;
  localparam logic [5:0] RA_SP_LO  = 6'h21;
  localparam logic [5:0] RA_SP_HI  = 6'h22;

  // Values after reset
  localparam logic [7:0]  STAT_RST = 8'h00;
  localparam logic [15:0] SP_RST   = 16'h07ff;
  localparam logic [15:0] PC_RST   = 16'h0000;

endpackage

// ==== testbench/cie_core_assertions.sv ====
`timescale 1ns/1ps
module cie_core_chk (
  // Clock and reset
  input logic        clk_sys,
  input logic        rst_b,
  // Instruction port and core state
  input logic        ins_valid,
  input logic [4:0]  ins_op,
  input logic [15:0] ins_k,
  input logic        ins_ready,
  input logic [15:0] pc,
  input logic [7:0]  status_flags,
  // Strobes
  input logic        pm_re,
  input logic        io_re,
  input logic        io_we
);
  logic        go;
  logic [15:0] tgt;
  logic [7:0]  fmsk;
  logic [7:0]  fexp;
  logic [3:0]  fhi;
  assign go = ins_valid & ins_ready;
  assign tgt = pc + {{9{ins_k[6]}}, ins_k[6:0]} + 16'h0001;
  // Odd codes of the flag group clear, even codes set
  assign fmsk = (ins_op inside {cie_pkg::OP_SETS, cie_pkg::OP_CLRS}) ? 8'h10
              : (ins_op inside {cie_pkg::OP_SETV, cie_pkg::OP_CLRV}) ? 8'h08
              : 8'h20;
  assign fexp = ins_op[0] ? (status_flags & ~fmsk) : (status_flags | fmsk);
  assign fhi = status_flags[7:4];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence s_jump;
    pc == $past(tgt) && !ins_ready ##1 ins_ready;
  endsequence
  sequence s_two;
    !ins_ready ##1 ins_ready;
  endsequence
  sequence s_pm;
    pm_re && !ins_ready ##1 !ins_ready ##1 ins_ready;
  endsequence

  AST_BR_T_TAKEN: assert property (
    go && ins_op == cie_pkg::OP_BRTCLR && !status_flags[6] |=> s_jump)
    else $error("branch on T clear missed its target");
  AST_BR_T_FALL: assert property (
    go && ins_op == cie_pkg::OP_BRTCLR && status_flags[6]
    |=> pc == $past(pc) + 16'h0001 && ins_ready)
    else $error("branch on T clear did not fall through");
  AST_BR_V_TAKEN: assert property (
    go && (ins_op == cie_pkg::OP_BRVSET && status_flags[3]
       || ins_op == cie_pkg::OP_BRVCLR && !status_flags[3])
    |=> status_flags == $past(status_flags) ##0 s_jump)
    else $error("overflow branch missed its target");
  AST_BR_I_TAKEN: assert property (
    go && (ins_op == cie_pkg::OP_BRIEN && status_flags[7]
       || ins_op == cie_pkg::OP_BRIDIS && !status_flags[7])
    |=> status_flags == $past(status_flags) ##0 s_jump)
    else $error("interrupt flag branch missed its target");
  AST_TWO_CYCLE: assert property (
    go && ins_op inside {cie_pkg::OP_LDIND, cie_pkg::OP_STIND,
      cie_pkg::OP_LDDIR, cie_pkg::OP_STDIR, cie_pkg::OP_PUSH,
      cie_pkg::OP_POP} |=> s_two)
    else $error("memory transfer did not take two cycles");
  AST_PM_READ: assert property (
    go && ins_op inside {cie_pkg::OP_PMRD, cie_pkg::OP_PMRD_R0} |=> s_pm)
    else $error("program memory read did not take three cycles");
  AST_IO_RMW: assert property (
    go && ins_op inside {cie_pkg::OP_IOSET, cie_pkg::OP_IOCLR}
    |=> io_re && !io_we ##1 io_we && ins_ready)
    else $error("io bit access out of sequence");
  AST_FLAG_ONE: assert property (
    go && ins_op inside {[cie_pkg::OP_SETS:cie_pkg::OP_CLRH]}
    |=> status_flags == $past(fexp) && ins_ready)
    else $error("flag set or clear touched the wrong flag");
  AST_ROTATE: assert property (
    go && ins_op inside {cie_pkg::OP_ROLC, cie_pkg::OP_RORC}
    |=> fhi == $past(fhi) && status_flags[3] ==
        (status_flags[2] ^ status_flags[0]))
    else $error("rotate flags wrong");
  AST_BIT_T: assert property (
    go && ins_op inside {cie_pkg::OP_BIT2T, cie_pkg::OP_T2BIT}
    |=> (status_flags & 8'hbf) == ($past(status_flags) & 8'hbf)
        && ins_ready)
    else $error("bit transfer changed a flag other than T");
endmodule

bind cie_core cie_core_chk chk_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .ins_valid(ins_valid),
  .ins_op(ins_op), .ins_k(ins_k), .ins_ready(ins_ready), .pc(pc),
  .status_flags(status_flags), .pm_re(pm_re), .io_re(io_re),
  .io_we(io_we)
);

// ==== testbench/cie_core_test.sv ====
`timescale 1ns/1ps
module cie_core_test;
  typedef struct packed {
    logic [4:0]  op;
    logic [3:0]  am;
    logic [4:0]  d;
    logic [15:0] k;
    logic [7:0]  flg;
    logic [15:0] dpc;
    logic [1:0]  cyc;
  } cie_row_t;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        ins_valid = 1'b0;
  logic [4:0]  ins_op = 5'h00;
  logic [4:0]  ins_d = 5'h00;
  logic [4:0]  ins_r = 5'h00;
  logic [15:0] ins_k = 16'h0000;
  logic [5:0]  ins_q = 6'h00;
  logic [2:0]  ins_b = 3'h0;
  logic [1:0]  ins_ptr = 2'h0;
  logic [1:0]  ins_mode = 2'h0;
  logic [5:0]  rb_addr = 6'h00;
  logic [7:0]  rb_wdata = 8'h00;
  logic        rb_wr = 1'b0;
  logic        rb_rd = 1'b0;
  logic [15:0] pm_rdata = 16'h0000;
  logic        ins_ready, dm_we, dm_re, pm_re, io_we, io_re;
  logic [15:0] pc, dm_addr, m_addr;
  logic [7:0]  status_flags, dm_wdata, dm_rdata, io_wdata, io_rdata;
  logic [7:0]  rb_rdata, m_data;
  logic [14:0] pm_addr;
  logic [4:0]  io_addr;
  logic [12:0] io_last;
  logic [15:0] pc_exp = 16'h0000;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          cyc;

  cie_row_t rows [15] = '{
    '{cie_pkg::OP_SETS,4'h0,5'h00,16'h0000,8'h10,16'h0001,2'h1},
    '{cie_pkg::OP_SETV,4'h0,5'h00,16'h0000,8'h18,16'h0001,2'h1},
    '{cie_pkg::OP_SETH,4'h0,5'h00,16'h0000,8'h38,16'h0001,2'h1},
    '{cie_pkg::OP_BRVSET,4'h0,5'h00,16'h0005,8'h38,16'h0006,2'h2},
    '{cie_pkg::OP_CLRV,4'h0,5'h00,16'h0000,8'h30,16'h0001,2'h1},
    '{cie_pkg::OP_BRVSET,4'h0,5'h00,16'h0005,8'h30,16'h0001,2'h1},
    '{cie_pkg::OP_BRVCLR,4'h0,5'h00,16'h007e,8'h30,16'hffff,2'h2},
    '{cie_pkg::OP_BRTCLR,4'h0,5'h00,16'h0003,8'h30,16'h0004,2'h2},
    '{cie_pkg::OP_BRIDIS,4'h0,5'h00,16'h0040,8'h30,16'hffc1,2'h2},
    '{cie_pkg::OP_BRIEN,4'h0,5'h00,16'h0005,8'h30,16'h0001,2'h1},
    '{cie_pkg::OP_CLRS,4'h0,5'h00,16'h0000,8'h20,16'h0001,2'h1},
    '{cie_pkg::OP_CLRH,4'h0,5'h00,16'h0000,8'h00,16'h0001,2'h1},
    '{cie_pkg::OP_LDDIR,4'h0,5'h03,16'h0123,8'h00,16'h0002,2'h2},
    '{cie_pkg::OP_PUSH,4'h0,5'h03,16'h0000,8'h00,16'h0001,2'h2},
    '{cie_pkg::OP_POP,4'h0,5'h04,16'h0000,8'h00,16'h0001,2'h2}
  };

  cie_core dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .ins_valid(ins_valid),
    .ins_op(ins_op), .ins_d(ins_d), .ins_r(ins_r), .ins_k(ins_k),
    .ins_q(ins_q), .ins_b(ins_b), .ins_ptr(ins_ptr),
    .ins_mode(ins_mode), .ins_ready(ins_ready), .pc(pc),
    .status_flags(status_flags), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re),
    .dm_rdata(dm_rdata), .pm_addr(pm_addr), .pm_re(pm_re),
    .pm_rdata(pm_rdata), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
    .rb_addr(rb_addr), .rb_wdata(rb_wdata), .rb_wr(rb_wr),
    .rb_rd(rb_rd), .rb_rdata(rb_rdata)
  );

  always #20 clk_sys = ~clk_sys;
  // Memories answer with address-derived bytes, I/O reads with 96; idle lines show a pattern
  assign dm_rdata = dm_re ? (dm_addr[7:0] ^ 8'h5a) : ~dm_addr[7:0];
  assign io_rdata = io_re ? 8'h96 : 8'h69;
  always @(posedge clk_sys) begin
    pm_rdata <= pm_re ? {~pm_addr[7:0], pm_addr[7:0]} : ~pm_rdata;
    if (dm_re | dm_we) begin
      m_addr <= dm_addr;
      m_data <= dm_wdata;
    end
    if (io_we)
      io_last <= {io_addr, io_wdata};
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      $display("wrong value timeout expected done seen hang");
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rb_w(input logic [5:0] a, input logic [7:0] v);
    rb_addr <= a;
    rb_wdata <= v;
    rb_wr <= 1'b1;
    @(posedge clk_sys);
    rb_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rb_r(input logic [5:0] a, input logic [7:0] v,
                      input string what);
    rb_addr <= a;
    rb_rd <= 1'b1;
    @(posedge clk_sys);
    rb_rd <= 1'b0;
    #1;
    chk(what, {8'h00, v}, {8'h00, rb_rdata});
    @(posedge clk_sys);
  endtask

  task automatic run(input cie_row_t w);
    ins_valid <= 1'b1;
    ins_op <= w.op;
    {ins_ptr, ins_mode} <= w.am;
    ins_d <= w.d;
    ins_r <= w.d;
    ins_b <= w.d[2:0];
    ins_q <= {1'b0, w.d};
    ins_k <= w.k;
    @(posedge clk_sys);
    ins_valid <= 1'b0;
    #1;
    cyc = 1;
    while (ins_ready !== 1'b1 && cyc < 5) begin
      @(posedge clk_sys);
      #1;
      cyc++;
    end
    pc_exp = pc_exp + w.dpc;
    chk("pc", pc_exp, pc);
    chk("flags", {8'h00, w.flg}, {8'h00, status_flags});
    chk("cycles", {14'h0000, w.cyc}, cyc[15:0]);
    @(posedge clk_sys);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    chk("reset pc", cie_pkg::PC_RST, pc);
    chk("reset ready", 16'h0000, {15'h0000, ins_ready});
    @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rb_r(cie_pkg::RA_SP_LO, cie_pkg::SP_RST[7:0], "sp low");
    rb_r(cie_pkg::RA_SP_HI, cie_pkg::SP_RST[15:8], "sp high");
    $display("test reset done");
    foreach (rows[i])
      run(rows[i]);
    $display("test table done");
    rb_w(6'h1a, 8'h10);
    rb_w(6'h1b, 8'h02);
    run('{cie_pkg::OP_LDIND,4'h1,5'h02,16'h0,8'h0,16'h1,2'h2});
    chk("ld addr", 16'h0210, m_addr);
    rb_r(6'h02, 8'h4a, "ld data");
    rb_r(6'h1a, 8'h11, "x inc");
    rb_w(6'h1c, 8'h00);
    rb_w(6'h1d, 8'h03);
    run('{cie_pkg::OP_STIND,4'h6,5'h02,16'h0,8'h0,16'h1,2'h2});
    chk("st addr", 16'h02ff, m_addr);
    chk("st data", 16'h004a, {8'h00, m_data});
    rb_r(6'h1d, 8'h02, "y dec");
    run('{cie_pkg::OP_LDIND,4'h2,5'h09,16'h0,8'h0,16'h1,2'h2});
    chk("ld dec addr", 16'h0210, m_addr);
    rb_r(6'h09, 8'h4a, "ld dec data");
    run('{cie_pkg::OP_STIND,4'h0,5'h09,16'h0,8'h0,16'h1,2'h2});
    chk("st plain addr", 16'h0210, m_addr);
    rb_r(6'h1a, 8'h10, "x kept");
    rb_w(6'h1e, 8'h0b);
    rb_w(6'h1f, 8'h04);
    run('{cie_pkg::OP_LDIND,4'hb,5'h05,16'h0,8'h0,16'h1,2'h2});
    chk("disp addr", 16'h0410, m_addr);
    rb_r(6'h1e, 8'h0b, "z kept");
    run('{cie_pkg::OP_STDIR,4'h0,5'h05,16'h0155,8'h0,16'h2,2'h2});
    chk("sts addr", 16'h0155, m_addr);
    chk("sts data", 16'h004a, {8'h00, m_data});
    run('{cie_pkg::OP_PMRD_R0,4'h0,5'h0,16'h0,8'h0,16'h1,2'h3});
    rb_r(6'h00, 8'hfa, "pm r0");
    run('{cie_pkg::OP_PMRD,4'h9,5'h08,16'h0,8'h0,16'h1,2'h3});
    rb_r(6'h08, 8'hfa, "pm rd");
    rb_r(6'h1e, 8'h0c, "pm z inc");
    $display("test pointers done");
    run('{cie_pkg::OP_IOSET,4'h0,5'h03,16'h5,8'h0,16'h1,2'h2});
    rb_r(6'h3f, 8'h00, "unmapped");
    chk("io set", 16'h059e, {3'h0, io_last});
    run('{cie_pkg::OP_IOCLR,4'h0,5'h02,16'h5,8'h0,16'h1,2'h2});
    rb_r(6'h3f, 8'h00, "unmapped");
    chk("io clear", 16'h0592, {3'h0, io_last});
    $display("test io done");
    rb_w(cie_pkg::RA_STATUS, 8'hc0);
    run('{cie_pkg::OP_BRTCLR,4'h0,5'h0,16'h5,8'hc0,16'h1,2'h1});
    run('{cie_pkg::OP_BRIEN,4'h0,5'h0,16'h7f,8'hc0,16'h0,2'h2});
    run('{cie_pkg::OP_BRIDIS,4'h0,5'h0,16'h5,8'hc0,16'h1,2'h1});
    rb_w(cie_pkg::RA_STATUS, 8'h00);
    rb_w(6'h07, 8'h80);
    run('{cie_pkg::OP_BIT2T,4'h0,5'h07,16'h0,8'h40,16'h1,2'h1});
    run('{cie_pkg::OP_T2BIT,4'h0,5'h06,16'h0,8'h40,16'h1,2'h1});
    rb_r(6'h06, 8'h40, "t to bit");
    rb_w(6'h01, 8'h81);
    run('{cie_pkg::OP_ROLC,4'h0,5'h01,16'h0,8'h49,16'h1,2'h1});
    rb_r(6'h01, 8'h02, "rol");
    run('{cie_pkg::OP_RORC,4'h0,5'h01,16'h0,8'h4c,16'h1,2'h1});
    rb_r(6'h01, 8'h81, "ror");
    $display("test flags done");
    report_and_stop();
  end
endmodule
